// [hdl/stimulus_condition_select_cfg_pkg.sv]
/*
  package for the stimulus-2 response configuration bank: register offsets,
  field positions, reset values, reserved codes and response selector codes.
  assumes a byte-wide register port addressed by the printed offsets.
*/
package stimulus_condition_select_cfg_pkg;
  // register offsets
  localparam logic [7:0] REG_RESP_OFS   = 8'h36;
  localparam logic [7:0] REG_PDTH_OFS   = 8'h37;
  localparam logic [7:0] REG_RATIO_OFS  = 8'h38;
  localparam logic [7:0] REG_COND_OFS   = 8'h80;
  // field positions
  localparam int MAG_LSB   = 4;
  localparam int SEL_LSB   = 0;
  localparam int PD_LSB    = 4;
  localparam int TH_LSB    = 0;
  localparam int RATIO_LSB = 0;
  localparam int COND_LSB  = 0;
  // reset values
  localparam logic [3:0] MAG_RST   = 4'h0;
  localparam logic [3:0] SEL_RST   = 4'h9;
  localparam logic [1:0] PD_RST    = 2'h0;
  localparam logic [3:0] TH_RST    = 4'h0;
  localparam logic [2:0] RATIO_RST = 3'h4;
  localparam logic [2:0] COND_RST  = 3'h0;
  // reserved codes
  localparam logic [3:0] MAG_RSVD   = 4'hf;
  localparam logic [3:0] TH_RSVD    = 4'hf;
  localparam logic [2:0] RATIO_RSVD = 3'h7;
  localparam logic [3:0] SEL_RSVD_A = 4'h5;
  localparam logic [3:0] SEL_RSVD_B = 4'h8;
  localparam logic [3:0] SEL_RSVD_C = 4'hb;
  localparam logic [2:0] COND_RSVD_A = 3'h4;
  localparam logic [2:0] COND_RSVD_B = 3'h5;
  // stimulus condition codes with a special meaning
  localparam logic [2:0] COND_SUPPLY_READY = 3'h0;
  localparam logic [2:0] COND_SUPPLY_ON    = 3'h7;
  // response selector codes
  localparam logic [3:0] SEL_REMOVE   = 4'h0;
  localparam logic [3:0] SEL_V_POS    = 4'h1;
  localparam logic [3:0] SEL_V_NEG    = 4'h2;
  localparam logic [3:0] SEL_V_BOTH   = 4'h3;
  localparam logic [3:0] SEL_R_POS    = 4'h4;
  localparam logic [3:0] SEL_DIV_POS  = 4'h6;
  localparam logic [3:0] SEL_R_NEG    = 4'h7;
  localparam logic [3:0] SEL_DIV_NEG  = 4'h9;
  localparam logic [3:0] SEL_SHORT    = 4'ha;
  localparam logic [3:0] SEL_DIV_BOTH = 4'hc;
  localparam logic [3:0] SEL_R_BOTH   = 4'hd;
  localparam logic [3:0] SEL_KEEP_A   = 4'he;
  localparam logic [3:0] SEL_KEEP_B   = 4'hf;
  // pull-down magnitude code and the decode table kind of each response
  localparam logic [3:0] MAG_PULLDOWN = 4'h0;
  typedef enum logic [2:0] {
    KIND_NONE    = 3'b001,
    KIND_VOLTAGE = 3'b010,
    KIND_OTHER   = 3'b100
  } kind_t;
endpackage

// [hdl/stimulus_condition_select_response_cfg.sv]
/*
  configuration bank for the second preloaded charger-emulation stimulus.
  holds response select and magnitude, pull-down current and threshold,
  divider ratio, and the stimulus condition select, and decodes them into
  static controls for the analog response circuits on both data pins.
  assumes a simple register port: one-cycle strobes, read data one cycle
  later; the profile-running inputs come from the emulation sequencer.
*/
// Our own choice: strobed register access.
// Operation
// - magnitude field meaning depends on the response type selector
// - writes of reserved codes are refused; field keeps its old value
// - voltage selectors 1..3 decode magnitude to millivolts, 0000 is pull-down
// - resistor selectors 4, 7, 13..15 decode magnitude to a resistor value
// - divider selectors 6, 9, 12 decode magnitude to minimum divider resistance
// - selector 0000 removes any response from both data pins
// - selectors 1, 2, 3 apply voltage to positive, negative, both pins
// - selectors 4, 7, 13 resistor to ground; 10 shorts the pins
// - selectors 6, 9, 12 place divider tap on positive, negative, both pins
// - selector 14 keeps pull-downs at condition 000, removes at 111
// - selector 15 behaves the same as selector 14
// - single-pin responses keep pin pull-down at condition 000 if unused
// - two-bit field selects pull-down current 10/50/100/150 uA
// - threshold code 1111 reserved; threshold ignored at condition 000 or 111
// - current and threshold frozen and ignored while a legacy profile runs; only the threshold is flagged invalid, current stays on its output
// - three-bit divider ratio, code 111 reserved
// - divider ratio frozen and ignored while a standard profile runs
// - conditions 000 and 111 are supply conditions; no threshold used
`timescale 1ns/1ns
`default_nettype none

module stimulus_condition_select_response_cfg
(
  input  wire logic       I_CLK,
  input  wire logic       I_SRST,
  input  wire logic [7:0] I_ADDR,
  input  wire logic [7:0] I_WDATA,
  input  wire logic       I_WR,
  input  wire logic       I_RD,
  input  wire logic       I_LEGACY_ACTIVE,
  input  wire logic       I_STANDARD_ACTIVE,
  output logic      [7:0] O_RDATA,
  output logic      [3:0] O_RESPONSE_TYPE_SELECT,
  output logic      [3:0] O_RESPONSE_MAGNITUDE_CODE,
  output logic      [2:0] O_STIMULUS_CONDITION_SELECT,
  output logic      [1:0] O_PULLDOWN_CURRENT_SELECT,
  output logic      [3:0] O_DETECT_THRESHOLD_CODE,
  output logic            O_THRESHOLD_VALID,
  output logic      [2:0] O_DIVIDER_RATIO_CODE,
  output logic            O_RATIO_VALID,
  output logic            O_VOLTAGE_POS,
  output logic            O_VOLTAGE_NEG,
  output logic            O_PULLDOWN_MODE,
  output logic            O_RESISTOR_POS,
  output logic            O_RESISTOR_NEG,
  output logic            O_DIVIDER_POS,
  output logic            O_DIVIDER_NEG,
  output logic            O_PINS_SHORTED,
  output logic            O_REMOVE_ALL,
  output logic            O_KEEP_RESET_PD_POS,
  output logic            O_KEEP_RESET_PD_NEG,
  output logic      [2:0] O_MAGNITUDE_KIND
);

  // stored fields
  logic [3:0] sel_q;
  logic [3:0] sel_d;
  logic [3:0] mag_q;
  logic [3:0] mag_d;
  logic [1:0] pd_q;
  logic [1:0] pd_d;
  logic [3:0] th_q;
  logic [3:0] th_d;
  logic [2:0] ratio_q;
  logic [2:0] ratio_d;
  logic [2:0] cond_q;
  logic [2:0] cond_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // decoded pin controls, registered so the analog side sees no glitches
  logic       vpos_q;
  logic       vneg_q;
  logic       rpos_q;
  logic       rneg_q;
  logic       dpos_q;
  logic       dneg_q;
  logic       short_q;
  logic       rem_q;
  logic       pdm_q;
  logic       kpos_q;
  logic       kneg_q;
  logic       thv_q;
  logic       rtv_q;
  logic [2:0] kind_q;

  function automatic logic sel_reserved(input logic [3:0] s);
    sel_reserved = (s == stimulus_condition_select_cfg_pkg::SEL_RSVD_A) || (s == stimulus_condition_select_cfg_pkg::SEL_RSVD_B) ||
                   (s == stimulus_condition_select_cfg_pkg::SEL_RSVD_C);
  endfunction

  function automatic logic is_supply_cond(input logic [2:0] c);
    is_supply_cond = (c == stimulus_condition_select_cfg_pkg::COND_SUPPLY_READY) ||
                     (c == stimulus_condition_select_cfg_pkg::COND_SUPPLY_ON);
  endfunction

  // address decode
  wire hit_resp  = (I_ADDR == stimulus_condition_select_cfg_pkg::REG_RESP_OFS);
  wire hit_pdth  = (I_ADDR == stimulus_condition_select_cfg_pkg::REG_PDTH_OFS);
  wire hit_ratio = (I_ADDR == stimulus_condition_select_cfg_pkg::REG_RATIO_OFS);
  wire hit_cond  = (I_ADDR == stimulus_condition_select_cfg_pkg::REG_COND_OFS);

  wire [3:0] w_mag   = I_WDATA[stimulus_condition_select_cfg_pkg::MAG_LSB +: 4];
  wire [3:0] w_sel   = I_WDATA[stimulus_condition_select_cfg_pkg::SEL_LSB +: 4];
  wire [1:0] w_pd    = I_WDATA[stimulus_condition_select_cfg_pkg::PD_LSB +: 2];
  wire [3:0] w_th    = I_WDATA[stimulus_condition_select_cfg_pkg::TH_LSB +: 4];
  wire [2:0] w_ratio = I_WDATA[stimulus_condition_select_cfg_pkg::RATIO_LSB +: 3];
  wire [2:0] w_cond  = I_WDATA[stimulus_condition_select_cfg_pkg::COND_LSB +: 3];

  // per-field write acceptance: a reserved code leaves only that field alone.
  // filtering per field rather than per register lets software change the
  // magnitude even when it sends a reserved selector in the same byte
  wire wr_sel   = I_WR && hit_resp && !sel_reserved(w_sel);
  wire wr_mag   = I_WR && hit_resp && (w_mag != stimulus_condition_select_cfg_pkg::MAG_RSVD);
  wire wr_pd    = I_WR && hit_pdth && !I_LEGACY_ACTIVE;
  wire wr_th    = I_WR && hit_pdth && !I_LEGACY_ACTIVE &&
                  (w_th != stimulus_condition_select_cfg_pkg::TH_RSVD);
  wire wr_ratio = I_WR && hit_ratio && !I_STANDARD_ACTIVE &&
                  (w_ratio != stimulus_condition_select_cfg_pkg::RATIO_RSVD);
  wire wr_cond  = I_WR && hit_cond && (w_cond != stimulus_condition_select_cfg_pkg::COND_RSVD_A) &&
                  (w_cond != stimulus_condition_select_cfg_pkg::COND_RSVD_B);

  assign sel_d   = wr_sel ? w_sel : sel_q;
  assign mag_d   = wr_mag ? w_mag : mag_q;
  assign pd_d    = wr_pd ? w_pd : pd_q;
  assign th_d    = wr_th ? w_th : th_q;
  assign ratio_d = wr_ratio ? w_ratio : ratio_q;
  assign cond_d  = wr_cond ? w_cond : cond_q;

  // read mux; unmapped addresses read zero, unimplemented bits read zero.
  // data is forced to zero outside a read so the port never shows stale words
  assign rdata_d = !I_RD ? 8'h00 :
                   hit_resp  ? {mag_q, sel_q} :
                   hit_pdth  ? {2'h0, pd_q, th_q} :
                   hit_ratio ? {5'h0, ratio_q} :
                   hit_cond  ? {5'h0, cond_q} : 8'h00;

  // response decode from the stored selector
  wire sv_pos  = (sel_q == stimulus_condition_select_cfg_pkg::SEL_V_POS) || (sel_q == stimulus_condition_select_cfg_pkg::SEL_V_BOTH);
  wire sv_neg  = (sel_q == stimulus_condition_select_cfg_pkg::SEL_V_NEG) || (sel_q == stimulus_condition_select_cfg_pkg::SEL_V_BOTH);
  wire sr_pos  = (sel_q == stimulus_condition_select_cfg_pkg::SEL_R_POS) || (sel_q == stimulus_condition_select_cfg_pkg::SEL_R_BOTH);
  wire sr_neg  = (sel_q == stimulus_condition_select_cfg_pkg::SEL_R_NEG) || (sel_q == stimulus_condition_select_cfg_pkg::SEL_R_BOTH);
  wire sd_pos  = (sel_q == stimulus_condition_select_cfg_pkg::SEL_DIV_POS) || (sel_q == stimulus_condition_select_cfg_pkg::SEL_DIV_BOTH);
  wire sd_neg  = (sel_q == stimulus_condition_select_cfg_pkg::SEL_DIV_NEG) || (sel_q == stimulus_condition_select_cfg_pkg::SEL_DIV_BOTH);
  wire s_short = (sel_q == stimulus_condition_select_cfg_pkg::SEL_SHORT);
  wire s_rem   = (sel_q == stimulus_condition_select_cfg_pkg::SEL_REMOVE);
  wire s_keep  = (sel_q == stimulus_condition_select_cfg_pkg::SEL_KEEP_A) ||
                 (sel_q == stimulus_condition_select_cfg_pkg::SEL_KEEP_B);
  wire s_volt  = (sel_q <= stimulus_condition_select_cfg_pkg::SEL_V_BOTH) && !s_rem;
  wire s_res   = (sel_q == stimulus_condition_select_cfg_pkg::SEL_R_POS) || (sel_q == stimulus_condition_select_cfg_pkg::SEL_R_NEG) ||
                 (sel_q >= stimulus_condition_select_cfg_pkg::SEL_R_BOTH);
  wire s_div   = sd_pos || sd_neg;
  wire use_pos = sv_pos || sr_pos || sd_pos || s_short;
  wire use_neg = sv_neg || sr_neg || sd_neg || s_short;
  wire c_ready = (cond_q == stimulus_condition_select_cfg_pkg::COND_SUPPLY_READY);

  // which decode table the magnitude follows
  wire [2:0] kind_d = (s_volt) ? stimulus_condition_select_cfg_pkg::KIND_VOLTAGE :
                      (s_res || s_div) ? stimulus_condition_select_cfg_pkg::KIND_OTHER :
                      stimulus_condition_select_cfg_pkg::KIND_NONE;

  // reset pull-downs: kept on unused pins at condition 000 unless selector 0000; for the keep
  // selectors, kept at 000, dropped at 111, else the previous state holds.
  // the hold path feeds back the registered state, so a keep selector written
  // under a detect condition leaves whatever the last decode produced
  wire kpos_d = s_keep ? (c_ready ? 1'b1 :
                          (cond_q == stimulus_condition_select_cfg_pkg::COND_SUPPLY_ON) ? 1'b0 : kpos_q) :
                s_rem ? 1'b0 : (c_ready && !use_pos);
  wire kneg_d = s_keep ? (c_ready ? 1'b1 :
                          (cond_q == stimulus_condition_select_cfg_pkg::COND_SUPPLY_ON) ? 1'b0 : kneg_q) :
                s_rem ? 1'b0 : (c_ready && !use_neg);

  // configuration fields
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      sel_q   <= stimulus_condition_select_cfg_pkg::SEL_RST;
      mag_q   <= stimulus_condition_select_cfg_pkg::MAG_RST;
      pd_q    <= stimulus_condition_select_cfg_pkg::PD_RST;
      th_q    <= stimulus_condition_select_cfg_pkg::TH_RST;
      ratio_q <= stimulus_condition_select_cfg_pkg::RATIO_RST;
      cond_q  <= stimulus_condition_select_cfg_pkg::COND_RST;
      rdata_q <= 8'h00;
    end
    else
    begin
      sel_q   <= sel_d;
      mag_q   <= mag_d;
      pd_q    <= pd_d;
      th_q    <= th_d;
      ratio_q <= ratio_d;
      cond_q  <= cond_d;
      rdata_q <= rdata_d;
    end
  end

  // decoded analog controls follow the fields by one cycle
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      vpos_q  <= 1'b0;
      vneg_q  <= 1'b0;
      rpos_q  <= 1'b0;
      rneg_q  <= 1'b0;
      dpos_q  <= 1'b0;
      dneg_q  <= 1'b0;
      short_q <= 1'b0;
      rem_q   <= 1'b0;
      pdm_q   <= 1'b0;
      kpos_q  <= 1'b0;
      kneg_q  <= 1'b0;
      thv_q   <= 1'b0;
      rtv_q   <= 1'b0;
      kind_q <= stimulus_condition_select_cfg_pkg::KIND_NONE;
    end
    else
    begin
      vpos_q  <= sv_pos;
      vneg_q  <= sv_neg;
      rpos_q  <= sr_pos;
      rneg_q  <= sr_neg;
      dpos_q  <= sd_pos;
      dneg_q  <= sd_neg;
      short_q <= s_short;
      rem_q   <= s_rem;
      pdm_q   <= s_volt && (mag_q == stimulus_condition_select_cfg_pkg::MAG_PULLDOWN);
      kpos_q  <= kpos_d;
      kneg_q  <= kneg_d;
      thv_q   <= !is_supply_cond(cond_q) && !I_LEGACY_ACTIVE;
      rtv_q   <= s_div && !I_STANDARD_ACTIVE;
      kind_q  <= kind_d;
    end
  end

  assign O_RDATA                     = rdata_q;
  assign O_RESPONSE_TYPE_SELECT      = sel_q;
  assign O_RESPONSE_MAGNITUDE_CODE   = mag_q;
  assign O_STIMULUS_CONDITION_SELECT = cond_q;
  assign O_PULLDOWN_CURRENT_SELECT   = pd_q;
  assign O_DETECT_THRESHOLD_CODE     = th_q;
  assign O_THRESHOLD_VALID           = thv_q;
  assign O_DIVIDER_RATIO_CODE        = ratio_q;
  assign O_RATIO_VALID               = rtv_q;
  assign O_VOLTAGE_POS               = vpos_q;
  assign O_VOLTAGE_NEG               = vneg_q;
  assign O_PULLDOWN_MODE             = pdm_q;
  assign O_RESISTOR_POS              = rpos_q;
  assign O_RESISTOR_NEG              = rneg_q;
  assign O_DIVIDER_POS               = dpos_q;
  assign O_DIVIDER_NEG               = dneg_q;
  assign O_PINS_SHORTED              = short_q;
  assign O_REMOVE_ALL                = rem_q;
  assign O_KEEP_RESET_PD_POS         = kpos_q;
  assign O_KEEP_RESET_PD_NEG         = kneg_q;
  assign O_MAGNITUDE_KIND            = kind_q;

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_SRST);

  sequence resp_write_rsvd_s;
    I_WR && hit_resp && (w_mag == stimulus_condition_select_cfg_pkg::MAG_RSVD);
  endsequence

  mag_reject_a: assert property (resp_write_rsvd_s |=> $stable(mag_q))
    else $error("reserved magnitude was stored");
  sel_reject_a: assert property (I_WR && hit_resp && sel_reserved(w_sel) |=> $stable(sel_q))
    else $error("reserved selector was stored");
  sel_accept_a: assert property (I_WR && hit_resp && !sel_reserved(w_sel) |=> sel_q == $past(w_sel))
    else $error("valid selector not stored");
  th_reject_a: assert property (I_WR && hit_pdth && (w_th == stimulus_condition_select_cfg_pkg::TH_RSVD) |=> $stable(th_q))
    else $error("reserved threshold was stored");
  legacy_freeze_a: assert property (I_WR && hit_pdth && I_LEGACY_ACTIVE |=> $stable(pd_q))
    else $error("pull-down current changed in legacy profile");
  ratio_freeze_a: assert property (I_WR && hit_ratio && I_STANDARD_ACTIVE |=> $stable(ratio_q))
    else $error("ratio changed in standard profile");
  ratio_reject_a: assert property (I_WR && hit_ratio && (w_ratio == stimulus_condition_select_cfg_pkg::RATIO_RSVD) |=> $stable(ratio_q))
    else $error("reserved ratio was stored");
  remove_all_a: assert property (sel_q == stimulus_condition_select_cfg_pkg::SEL_REMOVE |=> O_REMOVE_ALL && !O_VOLTAGE_POS && !O_KEEP_RESET_PD_POS)
    else $error("remove selector left a response applied");
  voltage_pins_a: assert property (sel_q == stimulus_condition_select_cfg_pkg::SEL_V_BOTH |=> O_VOLTAGE_POS && O_VOLTAGE_NEG)
    else $error("voltage not applied to both pins");
  keep_drop_a: assert property (s_keep && cond_q == stimulus_condition_select_cfg_pkg::COND_SUPPLY_ON |=> !O_KEEP_RESET_PD_POS && !O_KEEP_RESET_PD_NEG)
    else $error("reset pull-downs not removed");
  thr_ignore_a: assert property (is_supply_cond(cond_q) |=> !O_THRESHOLD_VALID)
    else $error("threshold used under supply condition");
  read_data_a: assert property (I_RD && hit_resp |=> O_RDATA == {mag_q, sel_q})
    else $error("response register read back wrong");

  // field updates on accepted writes, and selector, magnitude, current and threshold hold without a write
  sequence pdth_write_legacy_s;
    I_WR && hit_pdth && I_LEGACY_ACTIVE;
  endsequence

  th_freeze_a: assert property (pdth_write_legacy_s |=> $stable(th_q))
    else $error("threshold changed in legacy profile");
  mag_accept_a: assert property (wr_mag |=> mag_q == $past(w_mag))
    else $error("valid magnitude not stored");
  pd_accept_a: assert property (wr_pd |=> pd_q == $past(w_pd))
    else $error("pull-down current not stored");
  ratio_accept_a: assert property (wr_ratio |=> ratio_q == $past(w_ratio))
    else $error("valid ratio not stored");
  cond_accept_a: assert property (wr_cond |=> cond_q == $past(w_cond))
    else $error("valid condition not stored");
  cond_reject_a: assert property (I_WR && hit_cond && !wr_cond |=> $stable(cond_q))
    else $error("reserved condition was stored");
  idle_hold_a: assert property (!I_WR |=> $stable({sel_q, mag_q, pd_q, th_q}))
    else $error("field moved without a write");
  read_idle_a: assert property (!I_RD |=> O_RDATA == 8'h00)
    else $error("read data shown outside a read");

  // pin routing per selector
  voltage_pos_a: assert property (sel_q == stimulus_condition_select_cfg_pkg::SEL_V_POS |=> O_VOLTAGE_POS)
    else $error("voltage not on positive pin");
  voltage_neg_a: assert property (sel_q == stimulus_condition_select_cfg_pkg::SEL_V_NEG |=> O_VOLTAGE_NEG)
    else $error("voltage not on negative pin");
  resistor_pos_a: assert property (sel_q == stimulus_condition_select_cfg_pkg::SEL_R_POS |=> O_RESISTOR_POS)
    else $error("resistor not on positive pin");
  resistor_both_a: assert property (sel_q == stimulus_condition_select_cfg_pkg::SEL_R_BOTH |=> O_RESISTOR_NEG)
    else $error("resistor not on both pins");
  short_pins_a: assert property (s_short |=> O_PINS_SHORTED && !O_RESISTOR_POS)
    else $error("pins not shorted");
  divider_neg_a: assert property (sel_q == stimulus_condition_select_cfg_pkg::SEL_DIV_NEG |=> O_DIVIDER_NEG)
    else $error("divider tap not on negative pin");
  divider_both_a: assert property (sel_q == stimulus_condition_select_cfg_pkg::SEL_DIV_BOTH |=> O_DIVIDER_POS)
    else $error("divider tap not on both pins");
  remove_none_a: assert property (s_rem |=> !(O_RESISTOR_POS || O_RESISTOR_NEG ||
                                  O_DIVIDER_POS || O_DIVIDER_NEG || O_PINS_SHORTED))
    else $error("remove selector left a path connected");

  // magnitude table in use
  volt_kind_a: assert property (s_volt |=> O_MAGNITUDE_KIND == stimulus_condition_select_cfg_pkg::KIND_VOLTAGE)
    else $error("voltage table not selected");
  res_kind_a: assert property (s_res |=> O_MAGNITUDE_KIND == stimulus_condition_select_cfg_pkg::KIND_OTHER)
    else $error("resistor table not selected");
  div_kind_a: assert property (s_div |=> O_MAGNITUDE_KIND == stimulus_condition_select_cfg_pkg::KIND_OTHER)
    else $error("divider table not selected");
  pulldown_mode_a: assert property (s_volt && mag_q == 4'h0 |=> O_PULLDOWN_MODE)
    else $error("pull-down mode not flagged");

  // reset pull-downs and profile gating
  keep_ready_a: assert property (s_keep && c_ready |=> O_KEEP_RESET_PD_POS)
    else $error("reset pull-down dropped at ready");
  keep_hold_a: assert property (s_keep && !is_supply_cond(cond_q) |=> $stable(kneg_q))
    else $error("keep state changed under detect condition");
  single_pin_a: assert property (c_ready && sel_q == 4'h1 |=> O_KEEP_RESET_PD_NEG)
    else $error("unused pin lost its pull-down");
  thr_legacy_a: assert property (I_LEGACY_ACTIVE |=> !O_THRESHOLD_VALID)
    else $error("threshold used in legacy profile");
  ratio_ignore_a: assert property (I_STANDARD_ACTIVE |=> !O_RATIO_VALID)
    else $error("ratio used in standard profile");
  ratio_valid_a: assert property (s_div && !I_STANDARD_ACTIVE |=> O_RATIO_VALID)
    else $error("ratio not used for divider");

endmodule

`default_nettype wire

// [test/tb.sv]
/*
  self-checking bench for the stimulus-2 response configuration bank.
  assumes the bank answers reads one cycle after the strobe and that the
  decoded controls settle two edges after a field or profile input changes.
*/
`timescale 1ns/1ns
`default_nettype none

module tb;
  logic       clk;
  logic       srst;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic       legacy;
  logic       standard;
  logic [7:0] rdata;
  logic [3:0] sel;
  logic [3:0] mag;
  logic [2:0] cond;
  logic [1:0] pd;
  logic [3:0] th;
  logic [2:0] ratio;
  logic       thv;
  logic       rv;
  logic       vp;
  logic       vn;
  logic       pdm;
  logic       rp;
  logic       rn;
  logic       dp;
  logic       dn;
  logic       sh;
  logic       rm;
  logic       kp;
  logic       kn;
  logic [2:0] kind;
  logic [3:0] m_sel;
  logic [3:0] m_mag;
  logic [2:0] m_cond;
  logic [1:0] m_pd;
  logic [3:0] m_th;
  logic [2:0] m_ratio;
  logic [7:0] d;
  integer     seed;
  int         n_errors;
  int         samples_checked;

  stimulus_condition_select_response_cfg uut
  (
    .I_CLK(clk), .I_SRST(srst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .I_LEGACY_ACTIVE(legacy), .I_STANDARD_ACTIVE(standard), .O_RDATA(rdata),
    .O_RESPONSE_TYPE_SELECT(sel), .O_RESPONSE_MAGNITUDE_CODE(mag),
    .O_STIMULUS_CONDITION_SELECT(cond), .O_PULLDOWN_CURRENT_SELECT(pd),
    .O_DETECT_THRESHOLD_CODE(th), .O_THRESHOLD_VALID(thv), .O_DIVIDER_RATIO_CODE(ratio),
    .O_RATIO_VALID(rv), .O_VOLTAGE_POS(vp), .O_VOLTAGE_NEG(vn), .O_PULLDOWN_MODE(pdm),
    .O_RESISTOR_POS(rp), .O_RESISTOR_NEG(rn), .O_DIVIDER_POS(dp), .O_DIVIDER_NEG(dn),
    .O_PINS_SHORTED(sh), .O_REMOVE_ALL(rm), .O_KEEP_RESET_PD_POS(kp),
    .O_KEEP_RESET_PD_NEG(kn), .O_MAGNITUDE_KIND(kind)
  );

  // free-running 250 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // comparisons: read data and the packed static outputs
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_out(input logic [33:0] got, input logic [33:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // model of the stored fields; a refused field keeps its old value
  task automatic model_reset;
    m_sel = 4'h9;
    m_mag = 4'h0;
    m_cond = 3'h0;
    m_pd = 2'h0;
    m_th = 4'h0;
    m_ratio = 3'h4;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    case (a)
      8'h36:
      begin
        if (v[7:4] != 4'hf) m_mag = v[7:4];
        if (!(v[3:0] inside {4'h5, 4'h8, 4'hb})) m_sel = v[3:0];
      end
      8'h37:
      begin
        if (!legacy) m_pd = v[5:4];
        if (!legacy && v[3:0] != 4'hf) m_th = v[3:0];
      end
      8'h38: if (!standard && v[2:0] != 3'h7) m_ratio = v[2:0];
      8'h80: if (!(v[2:0] inside {3'h4, 3'h5})) m_cond = v[2:0];
      default: ;
    endcase
  endtask

  // read data stands only in the cycle after the strobe, so sample it there
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  function automatic logic [7:0] exp_reg(input logic [7:0] a);
    case (a)
      8'h36:   return {m_mag, m_sel};
      8'h37:   return {2'b00, m_pd, m_th};
      8'h38:   return {5'b00000, m_ratio};
      8'h80:   return {5'b00000, m_cond};
      default: return 8'h00;
    endcase
  endfunction

  // expected decode; selectors without a magnitude table report no table
  function automatic logic [33:0] exp_out;
    logic [2:0] k;
    k = (m_sel inside {4'h1, 4'h2, 4'h3}) ? 3'b010 :
        (m_sel inside {4'h4, 4'h6, 4'h7, 4'h9, 4'hc, 4'hd, 4'he, 4'hf}) ? 3'b100 : 3'b001;
    return {m_sel, m_mag, m_cond, m_pd, m_th, m_ratio,
            m_sel inside {4'h1, 4'h3}, m_sel inside {4'h2, 4'h3},
            (m_sel inside {4'h1, 4'h2, 4'h3}) && m_mag == 4'h0,
            m_sel inside {4'h4, 4'hd}, m_sel inside {4'h7, 4'hd},
            m_sel inside {4'h6, 4'hc}, m_sel inside {4'h9, 4'hc},
            m_sel == 4'ha, m_sel == 4'h0,
            m_cond != 3'h0 && m_cond != 3'h7 && !legacy,
            (m_sel inside {4'h6, 4'h9, 4'hc}) && !standard, k};
  endfunction

  task automatic chk_all;
    logic [33:0] g;
    repeat (2) @(posedge clk);
    #1;
    g = {sel, mag, cond, pd, th, ratio, vp, vn, pdm, rp, rn, dp, dn, sh, rm, thv, rv, kind};
    chk_out(g, exp_out(), "static outputs");
    if (m_cond == 3'h0 && m_sel inside {4'h1, 4'h4, 4'h6})
      chk_reg({6'b0, kp, kn}, 8'h01, "keep on unused negative pin");
    if (m_cond == 3'h0 && m_sel inside {4'h2, 4'h7, 4'h9})
      chk_reg({6'b0, kp, kn}, 8'h02, "keep on unused positive pin");
    if (m_cond == 3'h0 && m_sel inside {4'h3, 4'ha, 4'hc, 4'hd})
      chk_reg({6'b0, kp, kn}, 8'h00, "keep with both pins used");
    if (m_sel == 4'h0) chk_reg({6'b0, kp, kn}, 8'h00, "keep after remove");
    if (m_sel >= 4'he && m_cond == 3'h0) chk_reg({6'b0, kp, kn}, 8'h03, "keep at ready");
    if (m_sel >= 4'he && m_cond == 3'h7) chk_reg({6'b0, kp, kn}, 8'h00, "keep at on");
  endtask

  task automatic do_reset;
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    model_reset();
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // watchdog: a hang counts as a mismatch
  initial
  begin
    #200000;
    n_errors++;
    summarize();
  end

  // main sequence: reset values, full selector sweep, random traffic, mid-run reset
  initial
  begin
    logic [7:0] a;
    logic [7:0] tbl [5];
    seed = 32'h7b71e676;
    srst = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    legacy = 1'b0;
    standard = 1'b0;
    n_errors = 0;
    samples_checked = 0;
    tbl = '{8'h36, 8'h37, 8'h38, 8'h80, 8'h40};
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    model_reset();
    foreach (tbl[i])
    begin
      rd_reg(tbl[i], d);
      chk_reg(d, exp_reg(tbl[i]), "reset value");
    end
    chk_all();
    $display("test reset values done");
    // every selector code, under the two supply conditions and one detect condition
    foreach (tbl[c])
    begin
      if (c < 3)
      begin
        wr_reg(8'h80, (c == 0) ? 8'h00 : (c == 1) ? 8'h07 : 8'h02);
        for (int s = 0; s < 16; s++)
        begin
          wr_reg(8'h36, {4'($random(seed)), 4'(s)});
          rd_reg(8'h36, d);
          chk_reg(d, exp_reg(8'h36), "selector sweep");
          chk_all();
        end
      end
    end
    $display("test selector sweep done");
    // random writes with profile inputs toggling, including reserved codes
    for (int i = 0; i < 300; i++)
    begin
      @(posedge clk);
      legacy <= 1'($random(seed));
      standard <= 1'($random(seed));
      a = tbl[$unsigned($random(seed)) % 5];
      wr_reg(a, 8'($random(seed)));
      rd_reg(a, d);
      chk_reg(d, exp_reg(a), "random readback");
      chk_all();
    end
    $display("test random traffic done");
    do_reset();
    rd_reg(8'h36, d);
    chk_reg(d, 8'h09, "second reset");
    $display("test second reset done");
    summarize();
  end
endmodule

`default_nettype wire
